// *** src/ovf_params.svh ***
// Offsets, field positions, reset values and timing figures of the overvoltage handler
`ifndef OVF_PARAMS_SVH
`define OVF_PARAMS_SVH

`define OVF_ADDR_THRESHOLD  16'h0055
`define OVF_ADDR_REACTION   16'h0056
`define OVF_ADDR_EXPONENT   16'hfe39

`define OVF_THR_EXP_MSB     15
`define OVF_THR_EXP_LSB     11
`define OVF_THR_MANT_MSB    10
`define OVF_REACT_RESP_MSB  7
`define OVF_REACT_RESP_LSB  6
`define OVF_REACT_RETRY_MSB 5
`define OVF_REACT_RETRY_LSB 3
`define OVF_REACT_DLY_MSB   2
`define OVF_EXP_MSB         5
`define OVF_EXP_LSB         3

`define OVF_RST_MANTISSA    11'h7ff
`define OVF_RST_REACTION    8'h00
`define OVF_RST_EXPONENT    3'h0

`define OVF_RETRY_INFINITE  3'h7

`define OVF_CLK_PERIOD_NS   25
`define OVF_TICK_NS         1000000
`define OVF_DELAY1_BASE_MS  12'h00a
`define OVF_D2_MS_0         12'h0fc
`define OVF_D2_MS_1         12'h22e
`define OVF_D2_MS_2         12'h39c
`define OVF_D2_MS_3         12'h4ec
`define OVF_D2_MS_4         12'h63c
`define OVF_D2_MS_5         12'h78c
`define OVF_D2_MS_6         12'h8dc
`define OVF_D2_MS_7         12'ha2c

`endif

// *** src/ovf_pkg.sv ***
// Types shared by the overvoltage handler
package ovf_pkg;
  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_RIDE_THROUGH,
    RESP_SHUTDOWN_RETRY,
    RESP_HOLD_OFF
  } ovf_resp_type;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DELAY,
    ST_OFF_WAIT,
    ST_HOLD,
    ST_LATCHED
  } ovf_state_type;
endpackage

// *** src/ovf_tick.sv ***
// Millisecond tick divider with restart
`timescale 1ns/10ps
module ovf_tick #(
  parameter int TICK_CYCLES = 40000
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic restart,
  output logic      tick
);
  import ovf_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          wrap;

  assign wrap  = (cnt_q == LAST);
  assign cnt_d = (restart || wrap) ? '0 : cnt_q + CW'(1);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= wrap && !restart;
    end
  end
endmodule

// *** src/ovf_handler.sv ***
// Input overvoltage fault detector and response sequencer with its registers
// Notes on behaviour
// - Fault flag rises whenever the measured input voltage exceeds the threshold.
// - Threshold bits 15:11 read back exponent from exponent register bits 5:3.
// - Threshold bits 10:0 are writable mantissa; threshold is mantissa shifted by exponent.
// - Response field bits 7:6; code 00 ignores the fault.
// - Code 01 keeps running for delay one, then retries if fault persists.
// - Code 10 shuts output off at once, then retries up to the count.
// - Code 11 holds output off while fault stays, reenables after it clears.
// - Delay code picks delay one 10..1280 ms and restart spacing 252..2604 ms.
// - Retry codes 0..6 give that many restarts; code 7 retries forever.
// - Retries exhausted with fault still present latch output off until reset.
// - Delay two spaces restarts; delay one precedes disabling the output.
`timescale 1ns/10ps
`include "ovf_params.svh"
module ovf_handler #(
  parameter int VW          = 18,
  parameter int TICK_CYCLES = `OVF_TICK_NS / `OVF_CLK_PERIOD_NS
) (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic [VW-1:0] input_voltage,
  input  wire logic [15:0]   reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [15:0]   reg_wdata,
  output logic [15:0]        reg_rdata,
  output logic               fault_flag,
  output logic               output_enable,
  output logic               fault_latched,
  output ovf_pkg::ovf_state_type fault_state
);
  import ovf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [11:0] delay1_ms(input logic [2:0] code);
    delay1_ms = `OVF_DELAY1_BASE_MS << code;
  endfunction

  function automatic logic [11:0] delay2_ms(input logic [2:0] code);
    logic [11:0] v;
    v = `OVF_D2_MS_0;
    unique case (code)
      3'h0: v = `OVF_D2_MS_0;
      3'h1: v = `OVF_D2_MS_1;
      3'h2: v = `OVF_D2_MS_2;
      3'h3: v = `OVF_D2_MS_3;
      3'h4: v = `OVF_D2_MS_4;
      3'h5: v = `OVF_D2_MS_5;
      3'h6: v = `OVF_D2_MS_6;
      3'h7: v = `OVF_D2_MS_7;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [10:0] mant_q;
  logic [7:0]  react_q;
  logic [2:0]  exp_q;
  logic        sel_thr;
  logic        sel_react;
  logic        sel_exp;
  logic [15:0] rd_mux;

  assign sel_thr   = (reg_addr == `OVF_ADDR_THRESHOLD);
  assign sel_react = (reg_addr == `OVF_ADDR_REACTION);
  assign sel_exp   = (reg_addr == `OVF_ADDR_EXPONENT);
  assign rd_mux    = sel_thr   ? {2'h0, exp_q, mant_q} :
                     sel_react ? {8'h00, react_q} :
                     sel_exp   ? {10'h000, exp_q, 3'h0} : 16'h0000;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mant_q    <= `OVF_RST_MANTISSA;
      react_q   <= `OVF_RST_REACTION;
      exp_q     <= `OVF_RST_EXPONENT;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && sel_thr)
        mant_q <= reg_wdata[`OVF_THR_MANT_MSB:0];
      if (reg_wr && sel_react)
        react_q <= reg_wdata[7:0];
      if (reg_wr && sel_exp)
        exp_q <= reg_wdata[`OVF_EXP_MSB:`OVF_EXP_LSB];
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold compare
  logic [VW-1:0] threshold;
  logic          over;

  assign threshold = VW'({{(VW-11){1'b0}}, mant_q} << exp_q);
  assign over      = (input_voltage > threshold);

  ////////////////////////////////////////////////////////////////////////////
  // Reaction fields and timer
  ovf_resp_type resp;
  logic [2:0]   retry_code;
  logic [2:0]   dly_code;
  logic [2:0]   used_q;
  logic [2:0]   used_d;
  logic         retry_ok;
  logic [11:0]  ms_left_q;
  logic [11:0]  ms_left_d;
  logic         load;
  logic [11:0]  load_val;
  logic         tick;
  logic         expired;

  assign resp       = ovf_resp_type'(react_q[`OVF_REACT_RESP_MSB:`OVF_REACT_RESP_LSB]);
  assign retry_code = react_q[`OVF_REACT_RETRY_MSB:`OVF_REACT_RETRY_LSB];
  assign dly_code   = react_q[`OVF_REACT_DLY_MSB:0];
  assign retry_ok   = (retry_code == `OVF_RETRY_INFINITE) || (used_q < retry_code);
  assign expired    = (ms_left_q == 12'h000);

  ovf_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rstn   (rstn),
    .restart(load),
    .tick   (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Response sequencer
  ovf_state_type state_d;

  always_comb begin
    state_d  = fault_state;
    load     = 1'b0;
    load_val = delay2_ms(dly_code);
    used_d   = used_q;
    unique case (fault_state)
      ST_RUN: begin
        if (!fault_flag) begin
          used_d = 3'h0;
        end else begin
          unique case (resp)
            RESP_IGNORE: state_d = ST_RUN;
            RESP_RIDE_THROUGH: begin
              state_d  = ST_DELAY;
              load     = 1'b1;
              load_val = delay1_ms(dly_code);
            end
            RESP_SHUTDOWN_RETRY: begin
              state_d = retry_ok ? ST_OFF_WAIT : ST_LATCHED;
              load    = 1'b1;
            end
            RESP_HOLD_OFF: state_d = ST_HOLD;
          endcase
        end
      end
      ST_DELAY: begin
        if (!fault_flag) begin
          state_d = ST_RUN;
        end else if (expired) begin
          state_d = retry_ok ? ST_OFF_WAIT : ST_LATCHED;
          load    = 1'b1;
        end
      end
      ST_OFF_WAIT: begin
        if (expired) begin
          state_d = ST_RUN;
          if (retry_code != `OVF_RETRY_INFINITE)
            used_d = used_q + 3'h1;
        end
      end
      ST_HOLD: begin
        if (!fault_flag)
          state_d = ST_RUN;
      end
      ST_LATCHED: state_d = ST_LATCHED;
      default: state_d = ST_LATCHED;
    endcase
  end

  assign ms_left_d = load ? load_val :
                     (tick && !expired) ? ms_left_q - 12'h001 : ms_left_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_state   <= ST_RUN;
      fault_flag    <= 1'b0;
      output_enable <= 1'b1;
      fault_latched <= 1'b0;
      used_q        <= 3'h0;
      ms_left_q     <= 12'h000;
    end else begin
      fault_state   <= state_d;
      fault_flag    <= over;
      output_enable <= (state_d == ST_RUN) || (state_d == ST_DELAY);
      fault_latched <= (state_d == ST_LATCHED);
      used_q        <= used_d;
      ms_left_q     <= ms_left_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_fault_detect;
    over |=> fault_flag;
  endproperty
  a_fault_detect: assert property (p_fault_detect) else $error("fault not raised");

  property p_exp_readback;
    reg_rd && sel_thr |=> reg_rdata[15:11] == {2'h0, $past(exp_q)};
  endproperty
  a_exp_readback: assert property (p_exp_readback) else $error("exponent readback wrong");

  property p_ignore;
    fault_state == ST_RUN && fault_flag && resp == RESP_IGNORE |=> output_enable;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore code disabled output");

  property p_ride;
    fault_state == ST_RUN && fault_flag && resp == RESP_RIDE_THROUGH
      |=> fault_state == ST_DELAY && output_enable && ms_left_q == delay1_ms($past(dly_code));
  endproperty
  a_ride: assert property (p_ride) else $error("ride-through entry wrong");

  property p_shutdown;
    fault_state == ST_RUN && fault_flag && resp == RESP_SHUTDOWN_RETRY |=> !output_enable;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown did not disable");

  property p_hold_release;
    fault_state == ST_HOLD && !fault_flag |=> output_enable && fault_state == ST_RUN;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold did not release");

  property p_infinite;
    retry_code == `OVF_RETRY_INFINITE && !fault_latched |=> !fault_latched;
  endproperty
  a_infinite: assert property (p_infinite) else $error("infinite retry latched");

  property p_latched;
    fault_latched |=> fault_latched && !output_enable;
  endproperty
  a_latched: assert property (p_latched) else $error("latched fault released");

  property p_restart;
    fault_state == ST_OFF_WAIT && expired |=> fault_state == ST_RUN && output_enable;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missing");
endmodule

// *** test/test_ovf_handler.sv ***
// Self-checking bench for the input overvoltage handler
`timescale 1ns/10ps
module test_ovf_handler;
  import ovf_pkg::*;
  logic          ref_clk;
  logic          rstn;
  logic [17:0]   input_voltage;
  logic [15:0]   reg_addr;
  logic          reg_wr;
  logic          reg_rd;
  logic [15:0]   reg_wdata;
  logic [15:0]   reg_rdata;
  logic          fault_flag;
  logic          output_enable;
  logic          fault_latched;
  ovf_state_type fault_state;
  int            err_total;
  int            n_checks;

  ////////////////////////////////////////////////////////////////////////////
  // Tick shortened to 4 clocks, so one ms is 4 cycles
  ovf_handler #(.VW(18), .TICK_CYCLES(4)) ovf_handler_inst (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .input_voltage (input_voltage),
    .reg_addr      (reg_addr),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .fault_flag    (fault_flag),
    .output_enable (output_enable),
    .fault_latched (fault_latched),
    .fault_state   (fault_state)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask

  task automatic set_v(input logic [17:0] v);
    @(negedge ref_clk);
    input_voltage = v;
  endtask

  // Counts cycles until output_enable shows the wanted level
  task automatic wait_oe(input logic v, input int lim, output int n);
    n = 0;
    while (output_enable !== v) begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        chk("output_enable", output_enable, v);
        give_verdict();
      end
    end
  endtask

  task automatic do_reset;
    @(negedge ref_clk);
    input_voltage = 18'h0;
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_regs;
    logic [15:0] d;
    rd(16'h0055, d); chk("threshold", d, 16'h07ff);
    rd(16'h0056, d); chk("reaction", d, 16'h0000);
    rd(16'h1234, d); chk("unmapped", d, 16'h0000);
    wr(16'hfe39, 16'h0028);
    rd(16'hfe39, d); chk("exponent", d, 16'h0028);
    wr(16'h0055, 16'hffff);
    rd(16'h0055, d); chk("threshold", d, 16'h2fff);
    wr(16'h0055, 16'h0064);
    rd(16'h0055, d); chk("threshold", d, 16'h2864);
  endtask

  // Threshold is 100 shifted by 5, i.e. 3200; reaction code 00
  task automatic sc_detect;
    set_v(18'd3200);
    repeat (3) @(negedge ref_clk);
    chk("fault_flag", fault_flag, 0);
    set_v(18'd3201);
    @(negedge ref_clk);
    chk("fault_flag", fault_flag, 1);
    repeat (60) @(negedge ref_clk);
    chk("output_enable", output_enable, 1);
    set_v(18'd0);
  endtask

  task automatic sc_hold;
    int n;
    wr(16'h0056, 16'h00c0);
    set_v(18'd3201);
    wait_oe(1'b0, 5, n); chk("hold_off_cycles", n, 2);
    repeat (20) @(negedge ref_clk);
    chk("output_enable", output_enable, 0);
    set_v(18'd0);
    wait_oe(1'b1, 5, n); chk("reenable_cycles", n, 2);
  endtask

  // Code 01, no retries, delay code 1: 20 ms ride-through
  task automatic sc_ride;
    int n;
    wr(16'h0056, 16'h0041);
    set_v(18'd3201);
    repeat (4) @(negedge ref_clk);
    chk("fault_state", {29'h0, fault_state}, {29'h0, ST_DELAY});
    chk("output_enable", output_enable, 1);
    wait_oe(1'b0, 200, n); chk("ride_in_range", (n >= 76 && n <= 81), 1);
    @(negedge ref_clk);
    chk("fault_latched", fault_latched, 1);
  endtask

  // After reset the threshold is 2047; code 10, one retry, delay code 0
  task automatic sc_shutdown;
    int n;
    wr(16'h0056, 16'h0088);
    set_v(18'd3201);
    wait_oe(1'b0, 5, n); chk("shutdown_cycles", n, 2);
    wait_oe(1'b1, 1100, n); chk("retry_in_range", (n >= 1007 && n <= 1011), 1);
    repeat (3) @(negedge ref_clk);
    chk("fault_latched", fault_latched, 1);
    chk("output_enable", output_enable, 0);
    set_v(18'd0);
    repeat (10) @(negedge ref_clk);
    chk("fault_latched", fault_latched, 1);
    chk("output_enable", output_enable, 0);
    do_reset();
    @(negedge ref_clk);
    chk("fault_latched", fault_latched, 0);
    chk("output_enable", output_enable, 1);
  endtask

  // Code 01, endless retries, delay code 0: ride 10 ms, restart after 252 ms, ride again
  task automatic sc_infinite;
    int n;
    wr(16'h0056, 16'h0078);
    set_v(18'd3201);
    wait_oe(1'b0, 60, n); chk("ride_in_range", (n >= 40 && n <= 45), 1);
    wait_oe(1'b1, 1100, n); chk("retry_in_range", (n >= 1007 && n <= 1011), 1);
    wait_oe(1'b0, 60, n); chk("ride_in_range", (n >= 40 && n <= 45), 1);
    chk("fault_latched", fault_latched, 0);
    chk("fault_state", {29'h0, fault_state}, {29'h0, ST_OFF_WAIT});
    set_v(18'd0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total     = 0;
    n_checks      = 0;
    rstn          = 1'b0;
    input_voltage = 18'h0;
    reg_addr      = 16'h0;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_wdata     = 16'h0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    sc_regs();
    sc_detect();
    sc_hold();
    sc_ride();
    do_reset();
    sc_shutdown();
    sc_infinite();
    give_verdict();
  end
endmodule
